/* File: verilog/pcs_core.sv */
`timescale 1ns/100ps
// What this block does
// - Rotates load carry with the bit shifted out, low for right, high for left.
// - Option register is six write-only bits loaded from working register.
// - Reset sets all six option bits to one.
// - Program counter holds next address and advances by one unless loaded.
// - Jump loads all nine counter bits from the instruction address field.
// - Counter low byte in data space maps onto counter bits seven to zero.
// - Call or low-byte destination loads bits seven to zero, clears bit eight.
// - Reset sets every counter bit, starting at the reset vector.
// - Reset clears the page select bits, selecting page zero.
// - Return stack has two nine-bit levels, hardware push and pop only.
// - Beyond two calls only the two newest returns are kept, silently.
// - Extra returns keep yielding the address last held in level two.
// - Literal return also loads the working register with its literal.
// - Indirect location has no storage; accesses act on the pointed register.
// - Indirect read with pointer zero returns zero.
// - Indirect write with pointer zero stores nothing; flags may still change.
// - Reset vector is 1FF; counter wraps to 000.
// - Watchdog and power-down flags ignore instruction writes.
// - Flag-updating writes to status drop the data on those three flags.
// - Pointer bits four to zero select addresses; bits seven to five read one.
module pcs_core #(
  parameter int RAM_WORDS = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [3:0]       op_i,
  input  wire logic [4:0]       file_addr_i,
  input  wire logic [8:0]       lit_i,
  input  wire logic             dest_file_i,
  input  wire logic [2:0]       bit_sel_i,
  input  wire logic             wdog_expiry_i,
  input  wire logic             power_down_i,
  output logic      [8:0]       pc_o,
  output logic      [7:0]       work_o,
  output logic      [7:0]       status_o,
  output logic      [5:0]       option_o,
  output logic      [7:0]       pointer_o,
  output logic      [7:0]       read_data_o
);
  // The address decode is fixed to a 32-entry data space
  if (RAM_WORDS != 32) begin
    $error("pcs_core serves exactly 32 data addresses");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [8:0] pc;
  logic [8:0] next_pc;
  logic [8:0] stack_one;
  logic [8:0] next_stack_one;
  logic [8:0] stack_two;
  logic [8:0] next_stack_two;
  logic [7:0] work;
  logic [7:0] next_work;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [5:0] option;
  logic [5:0] next_option;
  logic [4:0] pointer;
  logic [4:0] next_pointer;
  logic [7:0] ram [RAM_WORDS];
  logic       ram_we;
  logic [4:0] ram_addr;
  logic [7:0] result;
  logic [7:0] read_data;
  logic [7:0] next_read_data;

  pcs_pkg::pcs_op_t op;
  assign op = pcs_pkg::pcs_op_t'(op_i);

  function automatic logic [4:0] resolve(input logic [4:0] addr, input logic [4:0] ptr);
    return (addr == pcs_pkg::ADDR_INDIRECT) ? ptr : addr;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand read; the effective address is resolved through the pointer
  logic [4:0] eff_addr;
  logic [7:0] operand;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic       flag_op;

  always_comb begin
    eff_addr = resolve(file_addr_i, pointer);
    case (eff_addr)
      pcs_pkg::ADDR_INDIRECT: operand = pcs_pkg::READ_ZERO;
      pcs_pkg::ADDR_CNT_LOW:  operand = pc[7:0];
      pcs_pkg::ADDR_STATUS:   operand = status;
      pcs_pkg::ADDR_POINTER:  operand = {1'b1, pcs_pkg::PTR_HIGH_ONES, pointer};
      default:                operand = ram[eff_addr];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute
  always_comb begin
    next_pc        = pc + 9'h001;
    next_stack_one = stack_one;
    next_stack_two = stack_two;
    next_work      = work;
    next_status    = status;
    next_option    = option;
    next_pointer   = pointer;
    ram_we         = 1'b0;
    ram_addr       = eff_addr;
    result         = operand;
    sum9           = 9'h000;
    half5          = 5'h00;
    flag_op        = 1'b0;
    case (op)
      pcs_pkg::PCS_OP_JUMP: next_pc = lit_i;
      pcs_pkg::PCS_OP_CALL: begin
        next_stack_two = stack_one;
        next_stack_one = pc + 9'h001;
        next_pc        = {1'b0, lit_i[7:0]};
      end
      pcs_pkg::PCS_OP_RETLIT: begin
        next_pc        = stack_one;
        next_stack_one = stack_two;
        next_work      = lit_i[7:0];
      end
      pcs_pkg::PCS_OP_OPTLD: next_option = work[5:0];
      pcs_pkg::PCS_OP_MOVE: result = work;
      pcs_pkg::PCS_OP_ADD, pcs_pkg::PCS_OP_SUB: begin
        flag_op = 1'b1;
        if (op == pcs_pkg::PCS_OP_ADD) begin
          sum9  = {1'b0, operand} + {1'b0, work};
          half5 = {1'b0, operand[3:0]} + {1'b0, work[3:0]};
        end else begin
          sum9  = {1'b0, operand} + {1'b0, ~work} + 9'h001;
          half5 = {1'b0, operand[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
        end
        result = sum9[7:0];
        next_status[pcs_pkg::ST_CARRY] = sum9[8];
        next_status[pcs_pkg::ST_HALF]  = half5[4];
        next_status[pcs_pkg::ST_ZERO]  = (sum9[7:0] == 8'h00);
      end
      pcs_pkg::PCS_OP_LOGIC: begin
        result = operand & work;
        next_status[pcs_pkg::ST_ZERO] = ((operand & work) == 8'h00);
        flag_op = 1'b1;
      end
      pcs_pkg::PCS_OP_ROTR: begin
        result = {status[pcs_pkg::ST_CARRY], operand[7:1]};
        next_status[pcs_pkg::ST_CARRY] = operand[0];
        flag_op = 1'b1;
      end
      pcs_pkg::PCS_OP_ROTL: begin
        result = {operand[6:0], status[pcs_pkg::ST_CARRY]};
        next_status[pcs_pkg::ST_CARRY] = operand[7];
        flag_op = 1'b1;
      end
      pcs_pkg::PCS_OP_BITSET: result = operand | (8'h01 << bit_sel_i);
      default: ;
    endcase
    // Destination write for file operations
    if (dest_file_i && op >= pcs_pkg::PCS_OP_MOVE) begin
      case (eff_addr)
        pcs_pkg::ADDR_INDIRECT: ;
        // low byte write clears bit eight
        pcs_pkg::ADDR_CNT_LOW: next_pc = {1'b0, result};
        pcs_pkg::ADDR_STATUS: begin
          next_status[pcs_pkg::ST_PAGE_HI:pcs_pkg::ST_PAGE_LO] =
            result[pcs_pkg::ST_PAGE_HI:pcs_pkg::ST_PAGE_LO];
          if (!flag_op) begin
            next_status[2:0] = result[2:0];
          end
        end
        pcs_pkg::ADDR_POINTER: next_pointer = result[4:0];
        default: ram_we = 1'b1;
      endcase
    end else if (op >= pcs_pkg::PCS_OP_MOVE) begin
      next_work = result;
    end
    next_status[pcs_pkg::ST_WDOG]  = wdog_expiry_i;
    next_status[pcs_pkg::ST_PDOWN] = power_down_i;
    next_read_data = operand;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pc        <= pcs_pkg::PC_RESET;
      stack_one <= pcs_pkg::PC_WRAP;
      stack_two <= pcs_pkg::PC_WRAP;
      work      <= 8'h00;
      status    <= {pcs_pkg::PAGE_RESET, pcs_pkg::ST_LOW_RESET};
      option    <= pcs_pkg::OPT_RESET;
      pointer   <= 5'h00;
      read_data <= 8'h00;
    end else begin
      pc        <= next_pc;
      stack_one <= next_stack_one;
      stack_two <= next_stack_two;
      work      <= next_work;
      status    <= next_status;
      option    <= next_option;
      pointer   <= next_pointer;
      read_data <= next_read_data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ram_we) begin
      ram[ram_addr] <= result;
    end
  end

  assign pc_o        = pc;
  assign work_o      = work;
  assign status_o    = status;
  assign option_o    = option;
  assign pointer_o   = {1'b1, pcs_pkg::PTR_HIGH_ONES, pointer};
  assign read_data_o = read_data;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence call_s;
    op == pcs_pkg::PCS_OP_CALL;
  endsequence
  sequence ret_s;
    op == pcs_pkg::PCS_OP_RETLIT;
  endsequence

  // Reset is synchronous: an edge that samples it high must not start a step check
  pc_step_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i && op == pcs_pkg::PCS_OP_NONE |=> pc == $past(pc) + 9'h001)
    else $error("pc did not advance");
  jump_load_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    op == pcs_pkg::PCS_OP_JUMP |=> pc == $past(lit_i))
    else $error("jump target wrong");
  call_push_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    call_s |=> stack_one == $past(pc) + 9'h001 && stack_two == $past(stack_one) && !pc[8])
    else $error("call push wrong");
  ret_pop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ret_s |=> pc == $past(stack_one) && stack_one == $past(stack_two) && work == $past(lit_i[7:0]))
    else $error("return pop wrong");
  ret_twice_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ret_s ##1 ret_s |=> pc == $past(stack_two, 2))
    else $error("second return wrong");
  opt_reset_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> option == pcs_pkg::OPT_RESET && pc == pcs_pkg::PC_RESET)
    else $error("reset values wrong");
  opt_load_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    op == pcs_pkg::PCS_OP_OPTLD |=> option == $past(work[5:0]))
    else $error("option load wrong");
  ptr_ones_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    op == pcs_pkg::PCS_OP_MOVE && dest_file_i && eff_addr == pcs_pkg::ADDR_POINTER
    |=> pointer_o == {3'h7, $past(work[4:0])})
    else $error("pointer read value wrong");
  rot_right_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    op == pcs_pkg::PCS_OP_ROTR |=> status[0] == $past(operand[0]))
    else $error("rotate carry wrong");
  rot_left_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    op == pcs_pkg::PCS_OP_ROTL |=> status[pcs_pkg::ST_CARRY] == $past(operand[7]))
    else $error("rotate left carry wrong");
  pcl_write_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i && op == pcs_pkg::PCS_OP_MOVE && dest_file_i &&
    eff_addr == pcs_pkg::ADDR_CNT_LOW |=> pc == {1'b0, $past(work)})
    else $error("low byte write wrong");
  ind_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i && file_addr_i == pcs_pkg::ADDR_INDIRECT && pointer == pcs_pkg::ADDR_INDIRECT
    |=> read_data_o == pcs_pkg::READ_ZERO)
    else $error("indirect zero read wrong");
  ind_nostore_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    file_addr_i == pcs_pkg::ADDR_INDIRECT && pointer == pcs_pkg::ADDR_INDIRECT |-> !ram_we)
    else $error("indirect zero write stored");
  dev_flags_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> status[pcs_pkg::ST_WDOG] == $past(wdog_expiry_i) &&
                   status[pcs_pkg::ST_PDOWN] == $past(power_down_i))
    else $error("device flags wrong");
  add_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    op == pcs_pkg::PCS_OP_ADD
    |=> status[pcs_pkg::ST_ZERO] == (($past(operand) + $past(work)) == 8'h00))
    else $error("add zero flag wrong");
  page_reset_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> status[pcs_pkg::ST_PAGE_HI:pcs_pkg::ST_PAGE_LO] == pcs_pkg::PAGE_RESET)
    else $error("page bits not cleared");
endmodule

/* File: inc/pcs_pkg.sv */
package pcs_pkg;
  // Program counter and stack
  localparam int          PC_W          = 9;
  localparam logic [8:0]  PC_RESET      = 9'h1FF;
  localparam logic [8:0]  PC_WRAP       = 9'h000;
  // Data space addresses
  localparam logic [4:0]  ADDR_INDIRECT = 5'h00;
  localparam logic [4:0]  ADDR_CNT_LOW  = 5'h02;
  localparam logic [4:0]  ADDR_STATUS   = 5'h03;
  localparam logic [4:0]  ADDR_POINTER  = 5'h04;
  // Status field positions
  localparam int          ST_CARRY      = 0;
  localparam int          ST_HALF       = 1;
  localparam int          ST_ZERO       = 2;
  localparam int          ST_PDOWN      = 3;
  localparam int          ST_WDOG       = 4;
  localparam int          ST_PAGE_LO    = 5;
  localparam int          ST_PAGE_HI    = 7;
  // Reset values and fixed read values
  localparam logic [5:0]  OPT_RESET     = 6'h3F;
  localparam logic [2:0]  PAGE_RESET    = 3'h0;
  localparam logic [4:0]  ST_LOW_RESET  = 5'h18;
  localparam logic [1:0]  PTR_HIGH_ONES = 2'h3;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  // Operation codes presented by the decoder
  typedef enum logic [3:0] {
    PCS_OP_NONE   = 4'h0,
    PCS_OP_JUMP   = 4'h1,
    PCS_OP_CALL   = 4'h2,
    PCS_OP_RETLIT = 4'h3,
    PCS_OP_OPTLD  = 4'h4,
    PCS_OP_MOVE   = 4'h5,
    PCS_OP_ADD    = 4'h6,
    PCS_OP_SUB    = 4'h7,
    PCS_OP_LOGIC  = 4'h8,
    PCS_OP_ROTR   = 4'h9,
    PCS_OP_ROTL   = 4'hA,
    PCS_OP_BITSET = 4'hB
  } pcs_op_t;
endpackage

/* File: dv/pcs_core_tb.sv */
`timescale 1ns/100ps
module pcs_core_tb;
  logic       mclk_i;
  logic       sys_rst_i;
  logic [3:0] op_i;
  logic [4:0] file_addr_i;
  logic [8:0] lit_i;
  logic       dest_file_i;
  logic [2:0] bit_sel_i;
  logic       wdog_expiry_i;
  logic       power_down_i;
  logic [8:0] pc_o;
  logic [7:0] work_o;
  logic [7:0] status_o;
  logic [5:0] option_o;
  logic [7:0] pointer_o;
  logic [7:0] read_data_o;
  int         err_count;
  int         samples_checked;

  pcs_core dut (
    .mclk_i       (mclk_i),
    .sys_rst_i    (sys_rst_i),
    .op_i         (op_i),
    .file_addr_i  (file_addr_i),
    .lit_i        (lit_i),
    .dest_file_i  (dest_file_i),
    .bit_sel_i    (bit_sel_i),
    .wdog_expiry_i(wdog_expiry_i),
    .power_down_i (power_down_i),
    .pc_o         (pc_o),
    .work_o       (work_o),
    .status_o     (status_o),
    .option_o     (option_o),
    .pointer_o    (pointer_o),
    .read_data_o  (read_data_o)
  );

  always #50 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // One instruction, then an idle cycle: the idle edge advances the counter by one
  task automatic ex(input pcs_pkg::pcs_op_t op, input logic [4:0] fa, input logic [8:0] lit,
                    input logic df, input logic [2:0] bs = 3'h0);
    @(posedge mclk_i);
    op_i        <= op;
    file_addr_i <= fa;
    lit_i       <= lit;
    dest_file_i <= df;
    bit_sel_i   <= bs;
    @(posedge mclk_i);
    op_i <= pcs_pkg::PCS_OP_NONE;
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    chk("pc", 9'h1FF, pc_o);
    chk("option", 9'h03F, option_o);
    chk("page", 9'h000, status_o[7:5]);
    chk("pointer_hi", 9'h003, pointer_o[6:5]);
    @(posedge mclk_i);
    #1;
    chk("pc_wrap", 9'h000, pc_o);
    $display("test reset done");
  endtask

  task automatic t_stack;
    ex(pcs_pkg::PCS_OP_JUMP, 5'h00, 9'h1A5, 1'h0);
    chk("pc_jump", 9'h1A5, pc_o);
    ex(pcs_pkg::PCS_OP_CALL, 5'h00, 9'h145, 1'h0);
    chk("pc_call", 9'h045, pc_o);
    ex(pcs_pkg::PCS_OP_CALL, 5'h00, 9'h010, 1'h0);
    chk("pc_call2", 9'h010, pc_o);
    ex(pcs_pkg::PCS_OP_CALL, 5'h00, 9'h020, 1'h0);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h05A, 1'h0);
    chk("pc_ret1", 9'h012, pc_o);
    chk("work_ret", 9'h05A, work_o);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h0A5, 1'h0);
    chk("pc_ret2", 9'h047, pc_o);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h000, 1'h0);
    chk("pc_ret3", 9'h047, pc_o);
    ex(pcs_pkg::PCS_OP_CALL, 5'h00, 9'h030, 1'h0);
    ex(pcs_pkg::PCS_OP_CALL, 5'h00, 9'h040, 1'h0);
    // Two returns back to back, with no idle cycle between them
    @(posedge mclk_i);
    op_i  <= pcs_pkg::PCS_OP_RETLIT;
    lit_i <= 9'h011;
    @(posedge mclk_i);
    lit_i <= 9'h022;
    @(posedge mclk_i);
    op_i <= pcs_pkg::PCS_OP_NONE;
    #1;
    chk("pc_ret_pair", 9'h049, pc_o);
    chk("work_ret_pair", 9'h022, work_o);
    $display("test stack done");
  endtask

  task automatic t_option_pcl;
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h015, 1'h0);
    ex(pcs_pkg::PCS_OP_OPTLD, 5'h00, 9'h000, 1'h0);
    chk("option", 9'h015, option_o);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h033, 1'h0);
    ex(pcs_pkg::PCS_OP_JUMP, 5'h00, 9'h1F0, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_CNT_LOW, 9'h000, 1'h1);
    chk("pc_low_write", 9'h033, pc_o);
    ex(pcs_pkg::PCS_OP_JUMP, 5'h00, 9'h1F0, 1'h0);
    ex(pcs_pkg::PCS_OP_BITSET, pcs_pkg::ADDR_CNT_LOW, 9'h000, 1'h1, 3'h3);
    chk("pc_bit_set", 9'h0F9, pc_o);
    ex(pcs_pkg::PCS_OP_JUMP, 5'h00, 9'h1E0, 1'h0);
    ex(pcs_pkg::PCS_OP_ADD, pcs_pkg::ADDR_CNT_LOW, 9'h000, 1'h1);
    chk("pc_add", 9'h014, pc_o);
    $display("test option_pcl done");
  endtask

  task automatic t_indirect;
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h0A5, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, 5'h10, 9'h000, 1'h1);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h010, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_POINTER, 9'h000, 1'h1);
    chk("pointer", 9'h0F0, pointer_o);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_INDIRECT, 9'h000, 1'h0);
    chk("ind_read", 9'h0A5, read_data_o);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h03C, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_INDIRECT, 9'h000, 1'h1);
    ex(pcs_pkg::PCS_OP_MOVE, 5'h10, 9'h000, 1'h0);
    chk("ind_write", 9'h03C, read_data_o);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h000, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_POINTER, 9'h000, 1'h1);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h077, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_INDIRECT, 9'h000, 1'h1);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_INDIRECT, 9'h000, 1'h0);
    chk("ind_zero", 9'h000, read_data_o);
    ex(pcs_pkg::PCS_OP_MOVE, 5'h10, 9'h000, 1'h0);
    chk("ind_kept", 9'h03C, read_data_o);
    $display("test indirect done");
  endtask

  task automatic t_flags;
    @(posedge mclk_i);
    power_down_i <= 1'h0;
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h0FF, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_STATUS, 9'h000, 1'h1);
    chk("status_move", 9'h0F7, status_o);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h000, 1'h0);
    ex(pcs_pkg::PCS_OP_LOGIC, pcs_pkg::ADDR_STATUS, 9'h000, 1'h1);
    chk("status_page", 9'h000, status_o[7:5]);
    chk("status_zero", 9'h001, status_o[2]);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h001, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, 5'h10, 9'h000, 1'h1);
    ex(pcs_pkg::PCS_OP_ROTL, 5'h10, 9'h000, 1'h0);
    chk("carry_rotl", 9'h000, status_o[0]);
    ex(pcs_pkg::PCS_OP_ROTR, 5'h10, 9'h000, 1'h0);
    chk("carry_rotr", 9'h001, status_o[0]);
    ex(pcs_pkg::PCS_OP_BITSET, 5'h10, 9'h000, 1'h1, 3'h6);
    ex(pcs_pkg::PCS_OP_MOVE, 5'h10, 9'h000, 1'h0);
    chk("bit_set", 9'h041, read_data_o);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h00F, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, 5'h10, 9'h000, 1'h1);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h001, 1'h0);
    ex(pcs_pkg::PCS_OP_ADD, 5'h10, 9'h000, 1'h0);
    chk("flags_add", 9'h002, status_o[2:0]);
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h001, 1'h0);
    ex(pcs_pkg::PCS_OP_SUB, 5'h10, 9'h000, 1'h0);
    chk("flags_sub", 9'h003, status_o[2:0]);
    $display("test flags done");
  endtask

  task automatic t_reset_again;
    ex(pcs_pkg::PCS_OP_RETLIT, 5'h00, 9'h0E0, 1'h0);
    ex(pcs_pkg::PCS_OP_MOVE, pcs_pkg::ADDR_STATUS, 9'h000, 1'h1);
    chk("status_keep", 9'h0F0, status_o);
    ex(pcs_pkg::PCS_OP_OPTLD, 5'h00, 9'h000, 1'h0);
    chk("option_pre", 9'h020, option_o);
    @(posedge mclk_i);
    sys_rst_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    #1;
    chk("pc_again", 9'h1FF, pc_o);
    chk("option_again", 9'h03F, option_o);
    chk("page_again", 9'h000, status_o[7:5]);
    @(posedge mclk_i);
    #1;
    chk("pc_wrap_again", 9'h000, pc_o);
    $display("test reset_again done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count       = 0;
    samples_checked = 0;
    mclk_i          = 1'h0;
    sys_rst_i       = 1'h1;
    op_i            = pcs_pkg::PCS_OP_NONE;
    file_addr_i     = 5'h00;
    lit_i           = 9'h000;
    dest_file_i     = 1'h0;
    bit_sel_i       = 3'h0;
    wdog_expiry_i   = 1'h1;
    power_down_i    = 1'h1;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    t_reset;
    t_stack;
    t_option_pcl;
    t_indirect;
    t_flags;
    t_reset_again;
    stop_test;
  end
endmodule
